// [rtl/anvpa_map.vh]
// Timing and pin constants for the x32 page-mode memory controller.
// Assumes a 40 MHz clock; counts are derived from ns figures.
`ifndef ANVPA_MAP_VH
`define ANVPA_MAP_VH
// ==========================================
// Clock
`define ANVPA_CLK_PS 25000
// ==========================================
// Times in picoseconds as printed in ns
`define ANVPA_T_CYCLE_PS 45000
`define ANVPA_T_WPULSE_PS 25000
`define ANVPA_T_RECOV_PS 15000
`define ANVPA_T_READ_PS 45000
`define ANVPA_T_PAGE_READ_PS 20000
`define ANVPA_T_PWP_PS 7500
`define ANVPA_T_PWC_PS 30000
`define ANVPA_T_PGS_PS 10000
`define ANVPA_T_EP_PS 45000
`define ANVPA_T_HIZ_PS 15000
// ==========================================
// Cycle counts, least times rounded up
`define ANVPA_CYC(ps) (((ps) + `ANVPA_CLK_PS - 1) / `ANVPA_CLK_PS)
// Extra dwell for the two-flop read data synchroniser
`define ANVPA_SYNC_CYC 1
// ==========================================
// Command codes and sequencer timer width
`define ANVPA_CMD_READ 1'b0
`define ANVPA_CMD_WRITE 1'b1
`define ANVPA_TW 4
`endif

// [rtl/anvpa_timer.v]
// Down-counting wait timer used by the controller sequencer.
// Assumes one clock domain and a synchronous high reset.
module anvpa_timer #(
    parameter W = 4
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [W-1:0] count,
    output wire done
);
    reg [W-1:0] cnt_q;
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= {W{1'b0}};
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign done = (cnt_q == {W{1'b0}}) && !load;
endmodule

// [rtl/anvpa_ctrl.v]
// Host controller for an asynchronous x32 non-volatile SRAM-style memory.
// Assumes a user side on clk issuing one request at a time; memory pins async.
// Function
// - Write drives select and write strobe low; data pins carry the word.
// - Read holds select and output gate low, strobe high; memory drives word.
// - Output gate stays high during writes; write ends on strobe rising.
// - Single write strobe pulse lasts at least 25 ns.
// - Address is valid before the write strobe falls; page-write hits drive the address and the strobe fall on the same clock edge.
// - Page entry: page select low with select high 10 ns before select falls.
// - Page exit: page select high 10 ns before next select falls.
// - Upper address change opens a page; new low bits load adjacent words.
// - Select stays low through a page write; raising it aborts.
// - Page write strobe low and high at least 7.5 ns each.
// - Select stays low at least 45 ns per page access.
// - At least 30 ns from select falling to strobe rising in page writes.
// - On 8 Gb parts each bank select acts as the chip select.
`include "anvpa_map.vh"
module anvpa_ctrl #(
    parameter AW = 28,
    parameter DW = 32
) (
    input wire clk,
    input wire rst,
    input wire req_valid,
    input wire req_cmd,
    input wire req_page,
    input wire [AW-1:0] req_addr,
    input wire [DW-1:0] req_wdata,
    output reg req_ready,
    output reg rsp_valid,
    output reg [DW-1:0] rsp_rdata,
    output reg bank_low_select_n,
    output reg bank_high_select_n,
    output reg gate_n,
    output reg strobe_n,
    output reg page_select_n,
    output reg [AW-2:0] addr_o,
    output reg [DW-1:0] dq_o,
    output reg dq_oe_n,
    input wire [DW-1:0] dq_i
);
    // ==========================================
    // Cycle counts; integer results cut to the timer width on purpose
    localparam integer N_CYCLE = `ANVPA_CYC(`ANVPA_T_CYCLE_PS);
    localparam integer N_WP = `ANVPA_CYC(`ANVPA_T_WPULSE_PS);
    localparam integer N_REC = `ANVPA_CYC(`ANVPA_T_RECOV_PS);
    localparam integer N_RD = `ANVPA_CYC(`ANVPA_T_READ_PS) + `ANVPA_SYNC_CYC;
    localparam integer N_PRD = `ANVPA_CYC(`ANVPA_T_PAGE_READ_PS) + `ANVPA_SYNC_CYC;
    localparam integer N_PWP = `ANVPA_CYC(`ANVPA_T_PWP_PS);
    localparam integer N_PWC = `ANVPA_CYC(`ANVPA_T_PWC_PS);
    localparam integer N_PGS = `ANVPA_CYC(`ANVPA_T_PGS_PS);
    localparam integer N_EP = `ANVPA_CYC(`ANVPA_T_EP_PS);
    localparam integer N_HIZ = `ANVPA_CYC(`ANVPA_T_HIZ_PS);
    localparam [3:0] C_CYCLE = N_CYCLE[3:0];
    localparam [3:0] C_WP = N_WP[3:0];
    localparam [3:0] C_REC = N_REC[3:0];
    localparam [3:0] C_RD = N_RD[3:0];
    localparam [3:0] C_PRD = N_PRD[3:0];
    localparam [3:0] C_PWP = N_PWP[3:0];
    localparam [3:0] C_PWC = N_PWC[3:0];
    localparam [3:0] C_PGS = N_PGS[3:0];
    localparam [3:0] C_EP = N_EP[3:0];
    localparam [3:0] C_HIZ = N_HIZ[3:0];
    // ==========================================
    // States
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_MODE = 4'h1;
    localparam [3:0] S_RSEL = 4'h2;
    localparam [3:0] S_RDONE = 4'h3;
    localparam [3:0] S_WSTB = 4'h4;
    localparam [3:0] S_WREC = 4'h5;
    localparam [3:0] S_GAP = 4'h6;
    localparam [3:0] S_PHOLD = 4'h7;
    localparam [3:0] S_PWH = 4'h8;
    localparam [3:0] S_HIZ = 4'h9;
    reg [3:0] st_q;
    reg page_q;
    reg open_q;
    reg bank_q;
    reg cmd_q;
    reg [AW-4:0] upper_q;
    reg ep_q;
    reg [3:0] ep_cnt_q;
    reg [DW-1:0] dq_s1_q;
    reg [DW-1:0] dq_s2_q;
    reg tload;
    reg [3:0] tcount;
    wire tdone;
    wire bank_w = req_addr[AW-1];
    wire hit = open_q && page_q && (req_page == page_q) && (bank_w == bank_q) && (req_addr[AW-2:2] == upper_q);
    anvpa_timer #(.W(`ANVPA_TW)) u_tmr (
        .clk(clk),
        .rst(rst),
        .load(tload),
        .count(tcount),
        .done(tdone)
    );
    // Read data passes two flops; dwell times add one cycle of margin.
    always @(posedge clk) begin
        dq_s1_q <= dq_i;
        dq_s2_q <= dq_s1_q;
    end
    // Bank select low time counter, enforces the select low minimum per page access.
    always @(posedge clk) begin
        if (rst || bank_low_select_n && bank_high_select_n) begin
            ep_cnt_q <= 4'h0;
        end else if (ep_cnt_q != C_EP) begin
            ep_cnt_q <= ep_cnt_q + 4'h1;
        end
        ep_q <= rst ? 1'b0 : (ep_cnt_q == C_EP);
    end
    // ==========================================
    // Sequencer
    always @(posedge clk) begin
        tload <= 1'b0;
        tcount <= 4'h0;
        rsp_valid <= 1'b0;
        if (rst) begin
            st_q <= S_IDLE;
            req_ready <= 1'b0;
            bank_low_select_n <= 1'b1;
            bank_high_select_n <= 1'b1;
            gate_n <= 1'b1;
            strobe_n <= 1'b1;
            page_select_n <= 1'b1;
            addr_o <= {(AW-1){1'b0}};
            dq_o <= {DW{1'b0}};
            dq_oe_n <= 1'b1;
            rsp_rdata <= {DW{1'b0}};
            page_q <= 1'b0;
            open_q <= 1'b0;
            bank_q <= 1'b0;
            cmd_q <= 1'b0;
            upper_q <= {(AW-3){1'b0}};
        end else begin
            case (st_q)
            S_IDLE: begin
                req_ready <= 1'b1;
                if (req_valid && req_ready) begin
                    req_ready <= 1'b0;
                    addr_o <= req_addr[AW-2:0];
                    dq_o <= req_wdata;
                    // Command is kept here so the setup path never rereads the request pins
                    cmd_q <= req_cmd;
                    if (hit) begin
                        if (req_cmd == `ANVPA_CMD_WRITE) begin
                            gate_n <= 1'b1;
                            dq_oe_n <= 1'b0;
                            strobe_n <= 1'b0;
                            tload <= 1'b1;
                            tcount <= C_PWP;
                            st_q <= S_WSTB;
                        end else begin
                            dq_oe_n <= 1'b1;
                            gate_n <= 1'b0;
                            tload <= 1'b1;
                            tcount <= C_PRD;
                            st_q <= S_RSEL;
                        end
                    end else begin
                        // Close any open access first; also the page entry/exit lead time.
                        bank_low_select_n <= 1'b1;
                        bank_high_select_n <= 1'b1;
                        gate_n <= 1'b1;
                        page_select_n <= ~req_page;
                        page_q <= req_page;
                        open_q <= 1'b0;
                        bank_q <= bank_w;
                        upper_q <= req_addr[AW-2:2];
                        tload <= 1'b1;
                        tcount <= C_PGS;
                        st_q <= S_MODE;
                    end
                end else if (open_q && page_q && ep_q && req_valid && !hit) begin
                    st_q <= S_IDLE;
                end
            end
            S_MODE: begin
                if (tdone) begin
                    // One bank only, shared data pins.
                    bank_low_select_n <= bank_q;
                    bank_high_select_n <= ~bank_q;
                    open_q <= page_q;
                    tload <= 1'b1;
                    if (cmd_q == `ANVPA_CMD_WRITE) begin
                        gate_n <= 1'b1;
                        dq_oe_n <= 1'b0;
                        strobe_n <= 1'b0;
                        tcount <= page_q ? C_PWC : C_WP;
                        st_q <= S_WSTB;
                    end else begin
                        gate_n <= 1'b0;
                        tcount <= C_RD;
                        st_q <= S_RSEL;
                    end
                end
            end
            S_RSEL: begin
                if (tdone) begin
                    rsp_rdata <= dq_s2_q;
                    rsp_valid <= 1'b1;
                    st_q <= S_RDONE;
                end
            end
            S_RDONE: begin
                if (page_q) begin
                    st_q <= S_PHOLD;
                end else begin
                    gate_n <= 1'b1;
                    bank_low_select_n <= 1'b1;
                    bank_high_select_n <= 1'b1;
                    tload <= 1'b1;
                    tcount <= C_HIZ;
                    st_q <= S_HIZ;
                end
            end
            S_WSTB: begin
                if (tdone) begin
                    strobe_n <= 1'b1;
                    tload <= 1'b1;
                    tcount <= page_q ? C_PWP : C_REC;
                    st_q <= page_q ? S_PWH : S_WREC;
                end
            end
            S_PWH: begin
                if (tdone) begin
                    dq_oe_n <= 1'b1;
                    st_q <= S_PHOLD;
                end
            end
            S_WREC: begin
                if (tdone) begin
                    bank_low_select_n <= 1'b1;
                    bank_high_select_n <= 1'b1;
                    dq_oe_n <= 1'b1;
                    st_q <= S_GAP;
                end
            end
            S_HIZ: begin
                if (tdone) begin
                    st_q <= S_GAP;
                end
            end
            S_GAP: begin
                // Recovery after deselect; covers cycle time with margin.
                tload <= 1'b1;
                tcount <= C_CYCLE - C_WP;
                st_q <= S_PHOLD;
            end
            S_PHOLD: begin
                // Page stays open here; a miss closes it only after the low minimum.
                if (!open_q || ep_q) begin
                    if (tdone) begin
                        st_q <= S_IDLE;
                    end
                end
            end
            default: begin
                st_q <= S_IDLE;
            end
            endcase
        end
    end
endmodule

// [verif/anvpa_ctrl_asserts.sv]
// Pin checks for the x32 memory controller.
// Assumes a bind into anvpa_ctrl, one clock, sync high reset.
module anvpa_ctrl_asserts (
    input wire clk,
    input wire rst,
    input wire req_ready,
    input wire rsp_valid,
    input wire bank_low_select_n,
    input wire bank_high_select_n,
    input wire gate_n,
    input wire strobe_n,
    input wire page_select_n,
    input wire dq_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    wire on = !(bank_low_select_n && bank_high_select_n);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========
    // Checks
    chk_bank_excl: assert property (bank_low_select_n || bank_high_select_n)
        else $error("both banks selected");
    chk_write_pins: assert property (!strobe_n |-> on && gate_n && !dq_oe_n)
        else $error("bad write pins");
    chk_read_pins: assert property (!gate_n |-> on && strobe_n && dq_oe_n)
        else $error("bad read pins");
    chk_page_lead: assert property ($changed(page_select_n) |-> !on [*2])
        else $error("page select moved while selected");
    chk_reset_idle: assert property (disable iff (1'b0) rst |=> !on && gate_n && strobe_n
        && page_select_n && dq_oe_n && !req_ready) else $error("bad reset state");
    chk_select_min: assert property ($rose(on) |-> on[*2])
        else $error("select low too short");
    chk_strobe_lead: assert property ($rose(strobe_n) |-> on && $past(on, 2))
        else $error("strobe rose too soon");
    chk_desel_gap: assert property ($fell(on) |=> !on)
        else $error("deselect too short");
    cov_write: cover property ($rose(strobe_n));
    cov_page_read: cover property (rsp_valid && !page_select_n);
    cov_legacy_read: cover property (rsp_valid && page_select_n);
endmodule

bind anvpa_ctrl anvpa_ctrl_asserts chk_u (.clk(clk), .rst(rst), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .bank_low_select_n(bank_low_select_n), .bank_high_select_n(bank_high_select_n), .gate_n(gate_n),
    .strobe_n(strobe_n), .page_select_n(page_select_n), .dq_oe_n(dq_oe_n));

// [verif/anvpa_mem_model.sv]
// Behavioural x32 page-mode memory facing the controller.
// Assumes pins from anvpa_ctrl; times in ns, no clock here.
module anvpa_mem_model #(
    parameter real PAGE_NS = 15.0
) (
    input wire bank_low_select_n,
    input wire bank_high_select_n,
    input wire gate_n,
    input wire strobe_n,
    input wire page_select_n,
    input wire [26:0] addr_o,
    input wire [31:0] dq_o,
    input wire dq_oe_n,
    output logic [31:0] dq_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [int];
    logic [31:0] word;
    logic [24:0] upper_q;
    logic fast = 1'b0;
    realtime t_acc = 0;
    realtime t_gate = 0;
    wire sel_n = bank_low_select_n & bank_high_select_n;
    wire [27:0] key = {bank_low_select_n, addr_o};
    logic [31:0] pins = 32'h0;
    logic sel_was = 1'b1;
    wire rd = !sel_n && !gate_n && strobe_n;
    assign dq_i = pins;
    // ==========
    // Writes land at strobe rising, one word per pulse
    always @(posedge strobe_n) begin
        if (!sel_n && !dq_oe_n) mem[int'(key)] = dq_o;
    end
    // ==========
    // Access start; only a low-bit move inside an open page is fast
    // A select fall always starts a full array access
    always @(addr_o or sel_n) begin
        fast = !page_select_n && !sel_n && !sel_was && addr_o[26:2] === upper_q;
        sel_was = sel_n;
        upper_q = addr_o[26:2];
        t_acc = $realtime;
    end
    always @(negedge gate_n) t_gate = $realtime;
    // ==========
    // Floating bus shows a moving pattern; a read keeps the old word for 3 ns after access start
    always #1 begin
        word = mem.exists(int'(key)) ? mem[int'(key)] : 32'h0;
        if (rd && $realtime - t_acc >= (fast ? PAGE_NS : 45.0) && $realtime - t_gate >= 25.0)
            pins = word;
        else if (!(rd && $realtime - t_acc < 3.0))
            pins = ~pins;
    end
endmodule

// [verif/anvpa_ctrl_test.sv]
// Self-checking bench for anvpa_ctrl with the memory model.
// Assumes the design and model files are compiled first.
module anvpa_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, req_valid, req_cmd, req_page;
    logic [27:0] req_addr;
    logic [31:0] req_wdata;
    wire req_ready, rsp_valid, bank_low_select_n, bank_high_select_n, gate_n, strobe_n, page_select_n, dq_oe_n;
    wire [31:0] rsp_rdata, dq_o, dq_i;
    wire [26:0] addr_o;
    int n_mismatch = 0;
    int cmp_count = 0;
    int lat;
    anvpa_ctrl #(.AW(28), .DW(32)) dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_page(req_page), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bank_low_select_n(bank_low_select_n),
        .bank_high_select_n(bank_high_select_n), .gate_n(gate_n), .strobe_n(strobe_n),
        .page_select_n(page_select_n), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));
    anvpa_mem_model mem_u (.bank_low_select_n(bank_low_select_n), .bank_high_select_n(bank_high_select_n),
        .gate_n(gate_n), .strobe_n(strobe_n), .page_select_n(page_select_n), .addr_o(addr_o), .dq_o(dq_o),
        .dq_oe_n(dq_oe_n), .dq_i(dq_i));
    // ==========
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Request fields change only once idle is seen and stand until the take edge
    task automatic xfer(input logic c, input logic p, input logic [27:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        req_cmd <= c;
        req_page <= p;
        req_addr <= a;
        req_wdata <= d;
        req_valid <= 1'b1;
        @(posedge clk);
        while (req_ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        req_valid <= 1'b0;
        lat = 0;
        while (c == 1'b0 && rsp_valid !== 1'b1 && lat < 300) begin
            @(posedge clk);
            lat++;
        end
        q = rsp_rdata;
        chk({31'h0, n < 300 && lat < 300}, 32'h1);
    endtask
    // ==========
    // Scenarios
    task automatic t_legacy;
        logic [31:0] q;
        xfer(1'b1, 1'b0, 28'h0000123, 32'h89abcdef, q);
        xfer(1'b1, 1'b0, 28'h8000123, 32'h01234567, q);
        xfer(1'b0, 1'b0, 28'h0000123, 32'h0, q);
        chk(q, 32'h89abcdef);
        xfer(1'b0, 1'b0, 28'h8000123, 32'h0, q);
        chk(q, 32'h01234567);
    endtask
    task automatic t_page;
        logic [31:0] q;
        int miss;
        for (int i = 0; i < 4; i++) xfer(1'b1, 1'b1, 28'h0000540 | 28'(i ^ 2), 32'hc0de0000 + 32'(i), q);
        xfer(1'b0, 1'b0, 28'h0000541, 32'h0, q);
        miss = lat;
        chk(q, 32'hc0de0003);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 1'b1, 28'h0000540 | 28'(i ^ 1), 32'h0, q);
            chk(q, 32'hc0de0000 + 32'(i ^ 3));
            if (i > 0) chk({31'h0, lat < miss}, 32'h1);
        end
    endtask
    task automatic t_reset;
        logic [31:0] q;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        chk({26'h0, bank_low_select_n, bank_high_select_n, gate_n, strobe_n, page_select_n, req_ready}, 32'h3e);
        rst <= 1'b0;
        xfer(1'b0, 1'b0, 28'h0000123, 32'h0, q);
        chk(q, 32'h89abcdef);
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==========
    // Clock, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_cmd = 1'b0;
        req_page = 1'b0;
        req_addr = 28'h0;
        req_wdata = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_legacy();
        t_page();
        t_reset();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
endmodule
